/* File: pkg/stc_count_if.sv */
`timescale 1ns/1ps
interface stc_count_if;
  logic tick;
  logic clr_prescale;
  logic [1:0] prescale_sel;
  logic step;
  modport ctl (output tick, output clr_prescale, output prescale_sel, input step);
  modport pre (input tick, input clr_prescale, input prescale_sel, output step);
endinterface

/* File: pkg/stc_pkg.sv */
package stc_pkg;
  // Register byte addresses
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_COUNT_LOW = 4'h4;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h8;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'hC;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h10;
  localparam logic [4:0] ADDR_CLOCK_STATUS = 5'h14;
  // Control field positions
  localparam int CTL_ENABLE = 0;
  localparam int CTL_SOURCE = 1;
  localparam int CTL_NOSYNC = 2;
  localparam int CTL_OSC_EN = 3;
  localparam int CTL_PRESCALE_LO = 4;
  localparam int CTL_RUN_STATUS = 6;
  localparam int CTL_WIDE = 7;
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  // Instruction cycle is four system clocks
  localparam int INSTR_DIV = 4;
  typedef enum logic [1:0] {
    STC_SRC_INTERNAL,
    STC_SRC_EXT_SYNC,
    STC_SRC_EXT_ASYNC
  } stc_mode_type;
endpackage

/* File: tb/stc_timer_sva.sv */
`timescale 1ns/1ps
module stc_timer_sva (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Register bus
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  // Pins and events
  input wire logic i_osc_clock_selected,
  input wire logic i_special_event_trigger,
  input wire logic o_osc_run,
  input wire logic o_pins_forced_input,
  input wire logic o_overflow_irq
);
  localparam logic [7:0] AC = 8'(stc_pkg::ADDR_CONTROL);
  localparam logic [7:0] AL = 8'(stc_pkg::ADDR_COUNT_LOW);
  localparam logic [7:0] AH = 8'(stc_pkg::ADDR_COUNT_HIGH);
  localparam logic [7:0] AS = 8'(stc_pkg::ADDR_IRQ_STATUS);
  localparam logic [7:0] AM = 8'(stc_pkg::ADDR_IRQ_MASK);
  localparam logic [7:0] AK = 8'(stc_pkg::ADDR_CLOCK_STATUS);
  ////////////////////////////////////////////////////////////////////////////////
  // Write access edge and read setup edge
  logic wr;
  logic rd;
  assign wr = i_psel & i_penable & i_pwrite;
  assign rd = i_psel & !i_penable & !i_pwrite;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  ////////////////////////////////////////////////////////////////////////////////
  a_osc_follow: assert property (wr && i_paddr == AC |=> o_osc_run == $past(i_pwdata[3]))
    else $error("osc run not following control write");
  a_pins_forced: assert property (o_pins_forced_input == o_osc_run)
    else $error("pin forcing differs from osc run");
  a_irq_masked: assert property (wr && i_paddr == AM && !i_pwdata[0] |=> !o_overflow_irq)
    else $error("irq high with mask cleared");
  a_irq_reset: assert property ($fell(i_srst) |-> !o_overflow_irq)
    else $error("irq high after reset");
  a_irq_flag: assert property (rd && i_paddr == AS && o_overflow_irq |=> o_prdata[0])
    else $error("irq high without flag");
  a_run_status: assert property (rd && i_paddr == AC |=> o_prdata[6] == $past(i_osc_clock_selected))
    else $error("clock status bit wrong");
  a_clock_reg: assert property (rd && i_paddr == AK |=>
    o_prdata[1:0] == {$past(i_osc_clock_selected), $past(o_osc_run)})
    else $error("clock status register wrong");
  a_ctl_readback: assert property (wr && i_paddr == AC ##2 rd && i_paddr == AC |=>
    {o_prdata[7], o_prdata[5:0]} == {$past(i_pwdata[7], 3), $past(i_pwdata[5:0], 3)})
    else $error("control readback wrong");
  a_trig_clear: assert property ($past(i_special_event_trigger, 2) && !$past(i_psel) &&
    $past(i_paddr, 2) > AH && rd && i_paddr == AL |=> o_prdata[7:0] <= 8'h01)
    else $error("trigger did not clear count");
  // Main scenarios
  c_irq: cover property ($rose(o_overflow_irq));
  c_trig: cover property (i_special_event_trigger && wr && i_paddr == AL);
  c_wide: cover property (wr && i_paddr == AC && i_pwdata[7]);
endmodule // stc_timer_sva
bind stc_timer stc_timer_sva sva_u (
  .i_clock(i_clock),
  .i_srst(i_srst),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .i_pwrite(i_pwrite),
  .i_paddr(i_paddr),
  .i_pwdata(i_pwdata),
  .o_prdata(o_prdata),
  .i_osc_clock_selected(i_osc_clock_selected),
  .i_special_event_trigger(i_special_event_trigger),
  .o_osc_run(o_osc_run),
  .o_pins_forced_input(o_pins_forced_input),
  .o_overflow_irq(o_overflow_irq)
);

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] AC = 8'h00, AL = 8'h04, AH = 8'h08, AS = 8'h0C, AM = 8'h10, AK = 8'h14;
  logic i_clock = 1'h0, i_srst = 1'h1, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0, tw = 1'h0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rdat, v, seed = 32'h8D887717;
  logic i_ext_count_clock_pin = 1'h0, i_osc_in_pin = 1'h0, i_osc_clock_selected = 1'h0;
  logic i_special_event_trigger = 1'h0, o_pready, o_pslverr, o_osc_run, o_pins_forced_input, o_overflow_irq;
  int fail_count = 0, cmp_count = 0, cyc = 0, n, m;
  stc_timer dut_u (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .i_ext_count_clock_pin(i_ext_count_clock_pin),
    .i_osc_in_pin(i_osc_in_pin),
    .i_osc_clock_selected(i_osc_clock_selected),
    .i_special_event_trigger(i_special_event_trigger),
    .o_osc_run(o_osc_run),
    .o_pins_forced_input(o_pins_forced_input),
    .o_overflow_irq(o_overflow_irq)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial forever #10 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer, holding the request until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_special_event_trigger <= tw;
    @(posedge i_clock);
    i_penable <= 1'h1;
    do begin
      @(posedge i_clock);
    end while (o_pready !== 1'h1);
    rdat = o_prdata;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    i_special_event_trigger <= 1'h0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'h0, a, 32'h0);
    chk(nm, rdat, e);
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge i_clock);
    i_srst <= 1'h0;
    for (n = 0; n < 7; n++) rc(8'(n * 4), 32'h0, "rst");
    repeat (4) begin
      v = xs();
      i_osc_clock_selected <= v[9];
      apb(1'h1, AC, v & 32'hFE);
      rc(AC, {24'h0, v[7], i_osc_clock_selected, v[5:1], 1'h0}, "ctl");
      chk("osc", {o_pins_forced_input, o_osc_run}, {2{v[3]}});
      rc(AK, {30'h0, i_osc_clock_selected, v[3]}, "clk");
    end
    v = xs();
    apb(1'h1, AC, 32'h0);
    apb(1'h1, AH, {24'h0, v[15:8]});
    apb(1'h1, AL, {24'h0, v[7:0]});
    rc(AH, {24'h0, v[15:8]}, "hi");
    apb(1'h1, AC, 32'h80);
    apb(1'h1, AH, 32'h12);
    rc(AH, 32'h12, "buf");
    rc(AL, {24'h0, v[7:0]}, "lo16");
    rc(AH, {24'h0, v[15:8]}, "cap");
    apb(1'h1, AH, 32'h34);
    apb(1'h1, AL, 32'h56);
    apb(1'h1, AC, 32'h0);
    rc(AH, 32'h34, "h16");
    for (m = 0; m < 4; m++) begin
      apb(1'h1, AL, 32'h0);
      apb(1'h1, AH, 32'h0);
      apb(1'h1, AC, 32'(m << 4) | 32'h1);
      repeat ((4 << m) * 20 - 3) @(posedge i_clock);
      apb(1'h1, AC, 32'(m << 4));
      apb(1'h0, AL, 32'h0);
      v = rdat;
      chk("pre", 32'(v > 18 && v < 22), 32'h1);
      repeat (9) @(posedge i_clock);
      rc(AL, v, "hold");
    end
    for (m = 0; m < 3; m++) begin
      apb(1'h1, AL, 32'h0);
      apb(1'h1, AC, 32'h3 | 32'(m << 2));
      if (m == 2) repeat (8) @(posedge i_clock);
      repeat (10) begin
        i_ext_count_clock_pin <= (m != 2);
        i_osc_in_pin <= (m == 2);
        repeat (4) @(posedge i_clock);
        i_ext_count_clock_pin <= 1'h0;
        i_osc_in_pin <= 1'h0;
        repeat (4) @(posedge i_clock);
      end
      apb(1'h1, AC, 32'h0);
      rc(AL, 32'hA, "ext");
    end
    for (m = 1; m >= 0; m--) begin
      apb(1'h1, AM, 32'(m));
      apb(1'h1, AH, 32'hFF);
      apb(1'h1, AL, 32'hFE);
      apb(1'h1, AC, 32'h1);
      n = 0;
      while (o_overflow_irq !== 1'h1 && n < 40) begin
        @(posedge i_clock);
        n++;
      end
      chk("irq", o_overflow_irq, 32'(m));
      apb(1'h1, AC, 32'h0);
      rc(AS, 32'h1, "flag");
      @(posedge i_clock);
      chk("irqclr", o_overflow_irq, 32'h0);
      rc(AS, 32'h0, "rdclr");
    end
    apb(1'h1, AH, 32'h55);
    apb(1'h1, AL, 32'h66);
    tw = 1'h1;
    apb(1'h1, AM, 32'h0);
    tw = 1'h0;
    rc(AL, 32'h0, "trlo");
    rc(AH, 32'h0, "trhi");
    rc(AS, 32'h0, "trflag");
    tw = 1'h1;
    apb(1'h1, AL, 32'h77);
    tw = 1'h0;
    rc(AL, 32'h77, "trwin");
    conclude();
  end
endmodule // testbench

/* File: verilog/stc_prescaler.sv */
`timescale 1ns/1ps
module stc_prescaler (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Counter side
  stc_count_if.pre bus
);
  logic [2:0] div_reg;
  logic [2:0] div_next;
  logic [2:0] limit;

  // Terminal count for the selected ratio
  always_comb begin
    limit = 3'h0;
    case (bus.prescale_sel)
      2'h1: limit = 3'h1;
      2'h2: limit = 3'h3;
      2'h3: limit = 3'h7;
      default: limit = 3'h0;
    endcase
    div_next = (div_reg >= limit) ? 3'h0 : div_reg + 3'h1;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst || bus.clr_prescale) begin
      div_reg <= 3'h0;
    end else if (bus.tick) begin
      div_reg <= div_next;
    end
  end

  assign bus.step = bus.tick && (div_reg >= limit);
endmodule // stc_prescaler

/* File: verilog/stc_timer.sv */
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Sixteen bit up counter wraps FFFF to 0000 raising an overflow event.
// - Control bit 0 runs the counter; clearing it holds the count.
// - Control bit 7 selects buffered 16-bit access, else two byte accesses.
// - Read-only bit 6 shows the oscillator is supplying the system clock.
// - Two prescale bits divide input edges by 1, 2, 4 or 8.
// - Oscillator enable bit starts the oscillator; clearing powers it down.
// - With external source, bit 2 bypasses synchronization; ignored otherwise.
// - Bit 1 selects external pin rising edges, else instruction clock.
// - Modes are timer, synchronous counter and asynchronous counter.
// - Step per instruction cycle, or per external or oscillator rising edge.
// - Oscillator enabled forces shared pins to inputs reading zero.
// - Compare unit trigger input clears the count.
// - Oscillator keeps running in power-managed modes and can clock the system.
// - Wide mode low read captures high byte; low write loads it.
// - Wide mode high write spares prescaler; only low write clears it.
// - Overflow latches the flag; interrupt only while its enable is set.
// - Trigger reset never sets the flag; coinciding software write wins.
module stc_timer (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Clock pins and system
  input wire logic i_ext_count_clock_pin,
  input wire logic i_osc_in_pin,
  input wire logic i_osc_clock_selected,
  input wire logic i_special_event_trigger,
  // Oscillator and pin control
  output logic o_osc_run,
  output logic o_pins_forced_input,
  output logic o_overflow_irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers and next values
  logic [7:0] control_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [7:0] high_buffer_reg;
  logic overflow_flag_reg;
  logic overflow_irq_enable_reg;
  logic [1:0] instr_div_reg;
  logic ext_meta_reg;
  logic ext_sync_reg;
  logic ext_prev_reg;
  logic raw_prev_reg;
  // Clock path
  logic ext_level;
  logic instr_tick;
  logic ext_tick;
  // Bus decode
  logic wr;
  logic rd;
  logic write_low;
  logic write_high;
  logic read_low;
  logic read_status;
  logic wide;
  logic overflow;
  stc_pkg::stc_mode_type mode;
  stc_count_if cnt_if ();
  logic hit_control;
  logic hit_low;
  logic hit_high;
  logic hit_status;
  logic hit_mask;
  logic hit_clock;
  logic read_setup;
  logic write_control;
  logic write_mask;
  logic mask_next;
  logic flag_next;
  logic [7:0] control_view;
  logic [31:0] prdata_next;
  logic [15:0] count_inc;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode, zero wait states
  // Every transfer completes in its first access cycle; there is no error response
  assign wr = i_psel && i_penable && i_pwrite;
  assign rd = i_psel && i_penable && !i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
  assign wide = control_reg[stc_pkg::CTL_WIDE];

  // Register hits, shared by the write and read paths
  assign hit_control = (i_paddr == {4'h0, stc_pkg::ADDR_CONTROL});
  assign hit_low = (i_paddr == {4'h0, stc_pkg::ADDR_COUNT_LOW});
  assign hit_high = (i_paddr == {4'h0, stc_pkg::ADDR_COUNT_HIGH});
  assign hit_status = (i_paddr == {4'h0, stc_pkg::ADDR_IRQ_STATUS});
  assign hit_mask = (i_paddr == {3'h0, stc_pkg::ADDR_IRQ_MASK});
  assign hit_clock = (i_paddr == {3'h0, stc_pkg::ADDR_CLOCK_STATUS});

  // Strobes; side effects happen only in the access cycle
  assign write_control = wr && hit_control;
  assign write_mask = wr && hit_mask;
  assign write_low = wr && hit_low;
  assign write_high = wr && hit_high;
  assign read_low = rd && hit_low;
  assign read_status = rd && hit_status;
  // Read data is fetched in the setup cycle so that it stands in the access cycle
  assign read_setup = i_psel && !i_penable && !i_pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Clock source mode
  // The source bit picks timer or counter; the sync bit only matters for counters
  always_comb begin
    if (!control_reg[stc_pkg::CTL_SOURCE]) begin
      mode = stc_pkg::STC_SRC_INTERNAL;
    end else if (control_reg[stc_pkg::CTL_NOSYNC]) begin
      mode = stc_pkg::STC_SRC_EXT_ASYNC;
    end else begin
      mode = stc_pkg::STC_SRC_EXT_SYNC;
    end
  end

  // The oscillator runs from its enable bit alone, whatever the power state
  // oscillator enable
  assign o_osc_run = control_reg[stc_pkg::CTL_OSC_EN];
  assign o_pins_forced_input = control_reg[stc_pkg::CTL_OSC_EN];
  assign ext_level = control_reg[stc_pkg::CTL_OSC_EN] ? i_osc_in_pin : i_ext_count_clock_pin;

  // Instruction cycle divider
  // Free running, so the tick phase does not depend on when the timer starts
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      instr_div_reg <= 2'h0;
    end else begin
      instr_div_reg <= instr_div_reg + 2'h1;
    end
  end
  assign instr_tick = (instr_div_reg == 2'(stc_pkg::INSTR_DIV - 1));

  // External level synchroniser and edge history
  // Resets low, the idle level of the pins, so no false edge follows reset
  // Only the second stage feeds the synchronised edge detector
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      raw_prev_reg <= 1'b0;
    end else begin
      ext_meta_reg <= ext_level;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
      raw_prev_reg <= ext_level;
    end
  end

  // Step source per mode
  // The unsynchronised mode saves the synchroniser latency but still lives in
  // the one clock domain, so it cannot count while the system clock is stopped
  always_comb begin
    case (mode)
      stc_pkg::STC_SRC_INTERNAL: ext_tick = instr_tick;
      stc_pkg::STC_SRC_EXT_ASYNC: ext_tick = ext_level && !raw_prev_reg;
      default: ext_tick = ext_sync_reg && !ext_prev_reg;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler
  // Cleared by low byte writes so that a loaded count starts a full period
  // run gate
  assign cnt_if.tick = ext_tick && control_reg[stc_pkg::CTL_ENABLE];
  assign cnt_if.clr_prescale = write_low;
  assign cnt_if.prescale_sel = control_reg[stc_pkg::CTL_PRESCALE_LO +: 2];

  stc_prescaler u_prescaler (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .bus(cnt_if.pre)
  );

  // Only a counted step can wrap; loads and trigger clears never raise it
  // wrap detection
  assign overflow = cnt_if.step && (count_reg == stc_pkg::COUNT_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // Incremented count, wraps from all ones to zero
  assign count_inc = count_reg + 16'h0001;

  // Counter next value
  // Priority, lowest first: count step, trigger clear, software writes.
  // A write in the same cycle as a trigger keeps the written value.
  always_comb begin
    count_next = count_reg;
    if (cnt_if.step) begin
      count_next = count_inc;
    end
    if (i_special_event_trigger) begin
      count_next = stc_pkg::COUNT_RESET;
    end
    if (write_low) begin
      count_next[7:0] = i_pwdata[7:0];
      if (wide) begin
        count_next[15:8] = high_buffer_reg;
      end
    end
    // Byte mode writes the high byte directly
    if (write_high && !wide) begin
      count_next[15:8] = i_pwdata[7:0];
    end
  end

  // Count register
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      count_reg <= stc_pkg::COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // High byte buffer
  // Holds the high byte between the two halves of a wide access
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      high_buffer_reg <= 8'h00;
    end else if (wide && write_high) begin
      high_buffer_reg <= i_pwdata[7:0];
    end else if (wide && read_low) begin
      high_buffer_reg <= count_reg[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, mask and flag registers
  // Control register; bit 6 is stored but reads back the live status
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      control_reg <= stc_pkg::CONTROL_RESET;
    end else if (write_control) begin
      control_reg <= i_pwdata[7:0];
    end
  end

  // Mask next value, landing in the access cycle of its write
  always_comb begin
    mask_next = overflow_irq_enable_reg;
    if (write_mask) begin
      mask_next = i_pwdata[0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      overflow_irq_enable_reg <= 1'b0;
    end else begin
      overflow_irq_enable_reg <= mask_next;
    end
  end

  // Read clear is applied first, so a wrap in the same cycle wins
  // trigger never sets
  // latch overflow, set beats read clear
  always_comb begin
    flag_next = overflow_flag_reg;
    if (read_status) begin
      flag_next = 1'b0;
    end
    if (overflow) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      overflow_flag_reg <= 1'b0;
    end else begin
      overflow_flag_reg <= flag_next;
    end
  end

  // Registered from the next values, so it moves in step with the flag
  // gated request
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_overflow_irq <= 1'b0;
    end else begin
      o_overflow_irq <= flag_next && mask_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control as software sees it: bit 6 comes from the clock switch
  // live status bit
  assign control_view = {control_reg[7], i_osc_clock_selected, control_reg[5:0]};

  // Read data mux; unmapped offsets read zero
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (hit_control) begin
      prdata_next = {24'h0, control_view};
    end else if (hit_low) begin
      prdata_next = {24'h0, count_reg[7:0]};
    end else if (hit_high) begin
      prdata_next = {24'h0, wide ? high_buffer_reg : count_reg[15:8]};
    end else if (hit_status) begin
      // A wrap in the fetch cycle is shown too, so it is never lost
      prdata_next = {31'h0, overflow_flag_reg || overflow};
    end else if (hit_mask) begin
      prdata_next = {31'h0, overflow_irq_enable_reg};
    end else if (hit_clock) begin
      prdata_next = {30'h0, i_osc_clock_selected, o_osc_run};
    end
  end

  // Read data register, loaded only in the setup cycle of a read
  // The status clear happens later, in the access cycle
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_prdata <= 32'h0000_0000;
    end else if (read_setup) begin
      o_prdata <= prdata_next;
    end
  end
endmodule // stc_timer
